// [design/dscp_pkg.sv]
/*
 * Shared constants, state type and helper functions for the serial configuration port.
 * Assumes it is compiled before every module of the port and is used only by scoped names.
 */
package dscp_pkg;

	// ----------------------------------------------------------------
	// Register space
	// ----------------------------------------------------------------
	localparam int NUM_REGS = 32;
	localparam int FULL_ADDR_W = 13;
	localparam logic [4:0] CTRL_ADDR = 5'h00;
	localparam logic [4:0] FSC1_ADDR = 5'h02;
	localparam logic [4:0] KEEP_ADDR = 5'h04;
	localparam logic [4:0] STATUS_ADDR = 5'h07;
	localparam logic [4:0] ANA1_ADDR = 5'h0e;
	localparam logic [4:0] ANA2_ADDR = 5'h0f;
	localparam logic [4:0] VERSION_ADDR = 5'h1f;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] FSC1_RST = 8'h02;
	localparam logic [7:0] ANA1_RST = 8'hc0;
	localparam logic [7:0] ANA2_RST = 8'hca;
	localparam logic [7:0] OTHER_RST = 8'h00;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CTRL_DIR_BIT = 7;
	localparam int CTRL_LSB_BIT = 6;
	localparam int CTRL_SRST_BIT = 5;
	localparam int CTRL_LONG_BIT = 4;
	localparam int INS_RW_BIT = 7;
	localparam int INS_CNT_MSB = 6;
	localparam int INS_CNT_LSB = 5;
	localparam int INS_ADDR_MSB = 4;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int SCLK_MAX_HZ = 20_000_000;
	localparam int REF_CLK_HZ = 20_000_000;

	typedef enum logic [1:0] {st_ins_first, st_ins_second, st_data} dscp_state_t;

	function automatic logic [7:0] reg_default(input logic [4:0] a);
		reg_default = (a == CTRL_ADDR) ? CTRL_RST :
			(a == FSC1_ADDR) ? FSC1_RST :
			(a == ANA1_ADDR) ? ANA1_RST :
			(a == ANA2_ADDR) ? ANA2_RST : OTHER_RST;
	endfunction : reg_default

	function automatic logic [7:0] shift_in(input logic [7:0] sh, input logic d, input logic lsb_first);
		shift_in = lsb_first ? {d, sh[7:1]} : {sh[6:0], d};
	endfunction : shift_in

	function automatic logic [12:0] step_addr(input logic [12:0] a, input logic lsb_first);
		step_addr = lsb_first ? 13'(a + 13'h0001) : 13'(a - 13'h0001);
	endfunction : step_addr

endpackage : dscp_pkg

// [design/dscp_sync.sv]
/*
 * Three-stage synchroniser for independent level signals.
 * Assumes each bit is a slow level; a bit is accepted once stages two and three agree.
 */
`timescale 1ns/100ps
module dscp_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;
	logic [W-1:0] q_r;
	wire [W-1:0] agree = ~(s2_r ^ s3_r);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
			q_r <= '0;
		end else begin
			s1_r <= d;
			s2_r <= s1_r;
			s3_r <= s2_r;
			q_r <= (s3_r & agree) | (q_r & ~agree);
		end
	end

	assign q = q_r;

endmodule : dscp_sync

// [design/dscp_regfile.sv]
/*
 * Register store of the port, one byte per address, with the software reset.
 * Assumes the caller filters read-only and out-of-range addresses before writing.
 */
`timescale 1ns/100ps
module dscp_regfile (
	input wire logic clk,
	input wire logic rstn,
	input wire logic we,
	input wire logic [4:0] waddr,
	input wire logic [7:0] wdata,
	input wire logic [4:0] raddr,
	output logic [7:0] rdata,
	output logic [7:0] ctrl,
	output logic [dscp_pkg::NUM_REGS*8-1:0] all_regs
);

	logic [7:0] mem_r [dscp_pkg::NUM_REGS];
	wire is_ctrl = (waddr == dscp_pkg::CTRL_ADDR);
	wire srst = we & is_ctrl & wdata[dscp_pkg::CTRL_SRST_BIT];
	wire [7:0] ctrl_wdata = wdata & ~(8'h01 << dscp_pkg::CTRL_SRST_BIT);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < dscp_pkg::NUM_REGS; i++) begin
				mem_r[i] <= dscp_pkg::reg_default(5'(i));
			end
		end else if (srst) begin
			for (int i = 0; i < dscp_pkg::NUM_REGS; i++) begin
				if (5'(i) != dscp_pkg::CTRL_ADDR && 5'(i) != dscp_pkg::KEEP_ADDR) begin
					mem_r[i] <= dscp_pkg::reg_default(5'(i));
				end
			end
			mem_r[dscp_pkg::CTRL_ADDR] <= ctrl_wdata;
		end else if (we) begin
			mem_r[waddr] <= is_ctrl ? ctrl_wdata : wdata;
		end
	end

	assign rdata = mem_r[raddr];
	assign ctrl = mem_r[dscp_pkg::CTRL_ADDR];

	genvar g;
	generate
		for (g = 0; g < dscp_pkg::NUM_REGS; g++) begin : g_flat
			assign all_regs[g*8 +: 8] = mem_r[g];
		end
	endgenerate

endmodule : dscp_regfile

// [design/dscp_top.sv]
/*
 * Serial configuration port of the converter: serial engine on the serial clock,
 * a mirror of the registers and the pin-strap controls on the reference clock.
 * Assumes the serial clock only runs inside frames and that the master keeps
 * at least one byte time between register writes.
 */
`timescale 1ns/100ps
// Behaviour
// - Each cycle opens with one instruction byte on the first eight rising edges (two bytes in wide form).
// - Then one to four data bytes follow, count taken from the instruction.
// - Instruction bit 7 high means read, low means write.
// - Instruction bits 6..5 give byte count minus one.
// - Short form: bits 4..0 are the first address; later addresses are generated.
// - A written byte lands in its register on its own last bit.
// - Select may rise between whole bytes to stall; lowering it resumes.
// - Select rising mid-byte abandons the cycle and returns to idle.
// - Wide instruction flag set: two-byte instruction, address bits 12..8 then 7..0.
// - Addresses up to 0x1F map alike in both forms; master keeps short form.
// - Every incoming bit is taken on the rising serial-clock edge.
// - Read bits change on the rising serial-clock edge.
// - Both output pins float whenever select is high.
// - Shared data pin always receives; drives read data only with direction bit set.
// - Dedicated output pin carries read data only in four-wire use.
// - Bit-order flag picks MSB-first (zero) or LSB-first for all bytes.
// - MSB-first: address steps down after each data byte.
// - LSB-first: address steps up after each data byte.
// - Pin-strap mode high disables the port and turns pins into static controls.
// - Software reset bit restores all registers except 0 and 4.
// - Partial zero byte plus three zero bytes restores short MSB-first operation.
module dscp_top #(
	parameter logic [7:0] VERSION_ID = 8'h5a // Arbitrary identification value.
) (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic sclk,
	input wire logic select_n,
	input wire logic sdio_i,
	output logic sdio_o,
	output logic sdio_oe,
	input wire logic serial_out_pin_i,
	output logic serial_out_pin_o,
	output logic serial_out_pin_oe,
	input wire logic pin_mode,
	input wire logic [7:0] status_in,
	output logic [dscp_pkg::NUM_REGS*8-1:0] cfg_regs,
	output logic cfg_update,
	output logic pin_mode_active,
	output logic static_interp_2x,
	output logic [1:0] static_fsc,
	output logic static_fifo_en
);

	// ----------------------------------------------------------------
	// Serial clock domain: strap and status
	// ----------------------------------------------------------------
	logic pm_sk;
	logic [7:0] status_sk;

	dscp_sync #(.W(9)) u_sync_sk (
		.clk(sclk),
		.rstn(rstn),
		.d({pin_mode, status_in}),
		.q({pm_sk, status_sk})
	);

	// The strap reaches this domain only after four serial clocks, so a
	// master that keeps clocking while the strap rises may still land a few
	// bits; the strap is meant to change with the link idle.
	wire port_on = ~pm_sk;

	// ----------------------------------------------------------------
	// Serial clock domain: declarations
	// ----------------------------------------------------------------
	logic [2:0] bit_cnt_r;
	logic [2:0] bit_cnt_nxt;
	logic mid_byte_r;
	dscp_pkg::dscp_state_t state_r;
	dscp_pkg::dscp_state_t state_nxt;
	dscp_pkg::dscp_state_t state_cur;
	logic [7:0] sh_r;
	logic [7:0] tx_r;
	logic [7:0] tx_nxt;
	logic rw_r;
	logic [1:0] cnt_r;
	logic [12:0] addr_r;
	logic [12:0] addr_nxt;
	logic [7:0] ctrl;
	logic [7:0] rf_rdata;
	logic [4:0] xfer_addr_r;
	logic [7:0] xfer_data_r;
	logic xfer_tgl_r;

	wire sdio_dir = ctrl[dscp_pkg::CTRL_DIR_BIT];
	wire low_bit_first = ctrl[dscp_pkg::CTRL_LSB_BIT];
	wire wide_instruction_en = ctrl[dscp_pkg::CTRL_LONG_BIT];

	// ----------------------------------------------------------------
	// Bit counter
	// ----------------------------------------------------------------
	// The counter is cleared while select is high, so a stall on a byte
	// boundary leaves it at zero and the frame state is kept intact.
	wire sel_rst_n = rstn & ~select_n;

	assign bit_cnt_nxt = port_on ? 3'(bit_cnt_r + 3'h1) : 3'h0;

	always_ff @(posedge sclk or negedge sel_rst_n) begin
		if (!sel_rst_n) begin
			bit_cnt_r <= 3'h0;
		end else begin
			bit_cnt_r <= bit_cnt_nxt;
		end
	end

	// A byte was left open if the previous edge expected more bits but the
	// counter has since been cleared by select; the clock does not run
	// while select is high, so this is seen on the first edge after it.
	always_ff @(posedge sclk or negedge rstn) begin
		if (!rstn) begin
			mid_byte_r <= 1'b0;
		end else begin
			mid_byte_r <= (bit_cnt_nxt != 3'h0);
		end
	end

	wire abandon = mid_byte_r & (bit_cnt_r == 3'h0);
	assign state_cur = abandon ? dscp_pkg::st_ins_first : state_r;
	wire byte_done = port_on & (bit_cnt_r == 3'h7);

	// ----------------------------------------------------------------
	// Receive shifter and address decode
	// ----------------------------------------------------------------
	wire [7:0] rx_nxt = dscp_pkg::shift_in(sh_r, sdio_i, low_bit_first);
	wire in_second = (state_cur == dscp_pkg::st_ins_second);
	wire in_data = (state_cur == dscp_pkg::st_data);
	wire [12:0] short_addr = {8'h00, rx_nxt[dscp_pkg::INS_ADDR_MSB:0]};
	wire [12:0] wide_addr = {rx_nxt[dscp_pkg::INS_ADDR_MSB:0], 8'h00};
	wire [12:0] ins_addr = in_second ? {addr_r[12:8], rx_nxt} :
		(wide_instruction_en ? wide_addr : short_addr);
	wire [12:0] step = dscp_pkg::step_addr(addr_r, low_bit_first);
	wire [12:0] rd_full = in_data ? step : ins_addr;
	wire rd_in_range = (rd_full[12:5] == 8'h00);
	wire [4:0] rd_addr = rd_full[4:0];
	// Reads above the register space return zero instead of an alias, so a
	// wide address can never wrap onto a real register.
	wire [7:0] rd_data = !rd_in_range ? 8'h00 :
		(rd_addr == dscp_pkg::STATUS_ADDR) ? status_sk :
		(rd_addr == dscp_pkg::VERSION_ADDR) ? VERSION_ID : rf_rdata;

	// Status and version are read-only; high addresses do not exist.
	wire wr_in_range = (addr_r[12:5] == 8'h00);
	wire wr_ro = (addr_r[4:0] == dscp_pkg::STATUS_ADDR) || (addr_r[4:0] == dscp_pkg::VERSION_ADDR);
	wire wr_ok = byte_done & in_data & ~rw_r & wr_in_range & ~wr_ro;

	wire ins_last = (state_cur == dscp_pkg::st_ins_first) ? ~wide_instruction_en : in_second;
	wire more = (cnt_r != 2'h0);
	wire load_tx = byte_done & (ins_last | (in_data & more));

	// ----------------------------------------------------------------
	// Frame state machine
	// ----------------------------------------------------------------
	always_comb begin
		state_nxt = state_cur;
		addr_nxt = addr_r;
		if (byte_done) begin
			unique case (state_cur)
				dscp_pkg::st_ins_first: begin
					addr_nxt = ins_addr;
					state_nxt = wide_instruction_en ? dscp_pkg::st_ins_second : dscp_pkg::st_data;
				end
				dscp_pkg::st_ins_second: begin
					addr_nxt = ins_addr;
					state_nxt = dscp_pkg::st_data;
				end
				dscp_pkg::st_data: begin
					addr_nxt = more ? step : addr_r;
					state_nxt = more ? dscp_pkg::st_data : dscp_pkg::st_ins_first;
				end
				default: begin
					state_nxt = dscp_pkg::st_ins_first;
				end
			endcase
		end
	end

	// Outgoing bits move on the same rising edge that samples input, so
	// the first read bit is valid right after the last instruction edge.
	assign tx_nxt = load_tx ? rd_data :
		(in_data & rw_r) ? (low_bit_first ? {1'b0, tx_r[7:1]} : {tx_r[6:0], 1'b0}) : tx_r;

	always_ff @(posedge sclk or negedge rstn) begin
		if (!rstn) begin
			state_r <= dscp_pkg::st_ins_first;
			addr_r <= 13'h0000;
			sh_r <= 8'h00;
			tx_r <= 8'h00;
		end else if (port_on) begin
			state_r <= state_nxt;
			addr_r <= addr_nxt;
			sh_r <= rx_nxt;
			tx_r <= tx_nxt;
		end
	end

	// The first instruction byte fixes direction and length even in the
	// wide form, where the second byte only carries address bits.
	// An abandoned cycle also forgets its direction, so no stale read drives.
	always_ff @(posedge sclk or negedge rstn) begin
		if (!rstn) begin
			rw_r <= 1'b0;
			cnt_r <= 2'h0;
		end else if (byte_done && state_cur == dscp_pkg::st_ins_first) begin
			rw_r <= rx_nxt[dscp_pkg::INS_RW_BIT];
			cnt_r <= rx_nxt[dscp_pkg::INS_CNT_MSB:dscp_pkg::INS_CNT_LSB];
		end else if (abandon) begin
			rw_r <= 1'b0;
			cnt_r <= 2'h0;
		end else if (byte_done && in_data && more) begin
			cnt_r <= 2'(cnt_r - 2'h1);
		end
	end

	// ----------------------------------------------------------------
	// Serial-side register store
	// ----------------------------------------------------------------
	// A write to the control register retunes bit order and instruction
	// width from the next bit on; zero bytes after an abandon thus bring
	// the port back to short MSB-first form.
	dscp_regfile u_regs_sk (
		.clk(sclk),
		.rstn(rstn),
		.we(wr_ok),
		.waddr(addr_r[4:0]),
		.wdata(rx_nxt),
		.raddr(rd_addr),
		.rdata(rf_rdata),
		.ctrl(ctrl),
		.all_regs()
	);

	// ----------------------------------------------------------------
	// Output pins
	// ----------------------------------------------------------------
	// Drive follows the live state, so a read cut mid-byte lets the pins go
	// as soon as select falls again, before the next clock arrives.
	wire drive = ~select_n & port_on & rw_r & in_data;
	wire out_bit = low_bit_first ? tx_r[0] : tx_r[7];

	assign sdio_o = out_bit;
	assign sdio_oe = drive & sdio_dir;
	assign serial_out_pin_o = out_bit;
	assign serial_out_pin_oe = drive & ~sdio_dir;

	// ----------------------------------------------------------------
	// Write hand-off to the reference clock
	// ----------------------------------------------------------------
	// Address and data are held from the toggle until the next write, which
	// is at least eight serial clocks later; that outlasts the synchroniser.
	// The reference side never reads them outside that window.
	always_ff @(posedge sclk or negedge rstn) begin
		if (!rstn) begin
			xfer_addr_r <= 5'h00;
			xfer_data_r <= 8'h00;
			xfer_tgl_r <= 1'b0;
		end else if (wr_ok) begin
			xfer_addr_r <= addr_r[4:0];
			xfer_data_r <= rx_nxt;
			xfer_tgl_r <= ~xfer_tgl_r;
		end
	end

	// ----------------------------------------------------------------
	// Reference clock domain
	// ----------------------------------------------------------------
	logic tgl_s;
	logic pm_s;
	logic [3:0] pins_s;
	logic tgl_seen_r;
	logic cfg_update_r;
	logic pm_active_r;
	logic interp_r;
	logic [1:0] fsc_r;
	logic fifo_r;

	// The strap pins are plain levels here: in strap mode neither select nor
	// the serial clock carries timing, so three stages suffice for each.
	dscp_sync #(.W(6)) u_sync_ref (
		.clk(ref_clk),
		.rstn(rstn),
		.d({xfer_tgl_r, pin_mode, select_n, serial_out_pin_i, sclk, sdio_i}),
		.q({tgl_s, pm_s, pins_s})
	);

	wire upd = tgl_s ^ tgl_seen_r;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			tgl_seen_r <= 1'b0;
			cfg_update_r <= 1'b0;
		end else begin
			tgl_seen_r <= tgl_s;
			cfg_update_r <= upd;
		end
	end

	dscp_regfile u_regs_ref (
		.clk(ref_clk),
		.rstn(rstn),
		.we(upd),
		.waddr(xfer_addr_r),
		.wdata(xfer_data_r),
		.raddr(5'h00),
		.rdata(),
		.ctrl(),
		.all_regs(cfg_regs)
	);

	// In strap mode the serial pins are read as static levels instead.
	// Outside it every static control rests at zero.
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			pm_active_r <= 1'b0;
			interp_r <= 1'b0;
			fsc_r <= 2'h0;
			fifo_r <= 1'b0;
		end else begin
			pm_active_r <= pm_s;
			interp_r <= pm_s & pins_s[3];
			fsc_r <= pm_s ? pins_s[2:1] : 2'h0;
			fifo_r <= pm_s & pins_s[0];
		end
	end

	// The pulse and the mirror write take the same edge, so cfg_regs already
	// holds the new byte while cfg_update is high.
	assign cfg_update = cfg_update_r;
	assign pin_mode_active = pm_active_r;
	assign static_interp_2x = interp_r;
	assign static_fsc = fsc_r;
	assign static_fifo_en = fifo_r;

endmodule : dscp_top

// [tb/dscp_props.sv]
/*
 * Checker for the serial configuration port, watching only the top module's ports.
 * Assumes it is bound to every instance of the top module.
 */
`timescale 1ns/100ps
module dscp_props (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic sclk,
	input wire logic select_n,
	input wire logic sdio_i,
	input wire logic sdio_o,
	input wire logic sdio_oe,
	input wire logic serial_out_pin_i,
	input wire logic serial_out_pin_o,
	input wire logic serial_out_pin_oe,
	input wire logic pin_mode,
	input wire logic [7:0] status_in,
	input wire logic [dscp_pkg::NUM_REGS*8-1:0] cfg_regs,
	input wire logic cfg_update,
	input wire logic pin_mode_active,
	input wire logic static_interp_2x,
	input wire logic [1:0] static_fsc,
	input wire logic static_fifo_en
);
	// ----------------------------------------------------------------
	// Read drive window
	// ----------------------------------------------------------------
	sequence drive_start;
		$rose(sdio_oe || serial_out_pin_oe);
	endsequence
	sequence drive_byte;
		(sdio_oe || serial_out_pin_oe) [*8];
	endsequence
	read_window_a: assert property (@(posedge sclk) disable iff (!rstn || select_n)
		drive_start |-> drive_byte) else $error("read drive shorter than one byte");
	// ----------------------------------------------------------------
	// Pins and mirror
	// ----------------------------------------------------------------
	oe_idle_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		select_n |-> !sdio_oe && !serial_out_pin_oe) else $error("output driven while deselected");
	oe_excl_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		!(sdio_oe && serial_out_pin_oe)) else $error("both output pins driven");
	pin_copy_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		serial_out_pin_oe |-> serial_out_pin_o == sdio_o) else $error("output pins disagree");
	upd_pulse_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		cfg_update |=> !cfg_update) else $error("update pulse too long");
	cfg_cause_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		!$stable(cfg_regs) |-> ##[0:1] cfg_update) else $error("mirror changed without update");
	strap_quiet_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		pin_mode_active |-> !sdio_oe && !serial_out_pin_oe) else $error("drive in strap mode");
	static_zero_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		(!pin_mode_active) [*3] |-> !static_fifo_en && static_fsc == 2'h0 && !static_interp_2x)
		else $error("static control outside strap mode");
endmodule : dscp_props

bind dscp_top dscp_props u_props (.ref_clk, .rstn, .sclk, .select_n, .sdio_i, .sdio_o, .sdio_oe,
	.serial_out_pin_i, .serial_out_pin_o, .serial_out_pin_oe, .pin_mode, .status_in, .cfg_regs,
	.cfg_update, .pin_mode_active, .static_interp_2x, .static_fsc, .static_fifo_en);

// [tb/dscp_master.sv]
/*
 * Serial master model for the port's link, driven by bench task calls.
 * Assumes the bench resolves the shared line and calls one task at a time.
 */
`timescale 1ns/100ps
module dscp_master (
	output logic sclk,
	output logic select_n,
	output logic sd_o,
	output logic sd_oe,
	input wire logic sdio_line,
	input wire logic out_line
);
	initial begin
		sclk = 1'b0;
		select_n = 1'b1;
		sd_o = 1'b0;
		sd_oe = 1'b1;
	end
	// Clock stays low between frames; 8 MHz keeps margin below the limit.
	task automatic tick(output logic b, input logic use_out);
		#62.5 b = use_out ? out_line : sdio_line;
		sclk = 1'b1;
		#62.5 sclk = 1'b0;
	endtask : tick
	task automatic frame(input logic on);
		#62.5 select_n = ~on;
		#62.5;
	endtask : frame
	task automatic zeros(input int n);
		logic b;
		sd_oe = 1'b1;
		sd_o = 1'b0;
		repeat (n) tick(b, 1'b0);
	endtask : zeros
	task automatic level(input logic v);
		sd_oe = 1'b1;
		sd_o = v;
	endtask : level
	task automatic xbyte(input logic [7:0] d, input logic lsb, input logic rd, input logic use_out,
		output logic [7:0] q);
		logic b;
		sd_oe = ~rd;
		for (int i = 0; i < 8; i++) begin
			sd_o = d[lsb ? i : 7 - i];
			tick(b, use_out);
			q[lsb ? i : 7 - i] = b;
		end
		sd_oe = 1'b1;
	endtask : xbyte
endmodule : dscp_master

// [tb/dac_serial_config_port_tb_top.sv]
/*
 * Self-checking bench for the serial configuration port with a serial master model.
 * Assumes the port's package and design files are compiled first.
 */
`timescale 1ns/100ps
module dac_serial_config_port_tb_top;
	localparam logic [7:0] VER = 8'h5a; // Arbitrary value.
	logic ref_clk = 1'b0;
	logic rstn = 1'b0;
	logic pin_mode = 1'b0;
	logic junk = 1'b0;
	logic lsb = 1'b0;
	logic wide = 1'b0;
	logic [31:0] q;
	int miscompares = 0;
	int checks = 0;
	int cycles = 0;
	int upd_cnt = 0;
	logic [7:0] status = 8'h3c;
	wire sclk, select_n, sd_o, sd_oe, sdio_o, sdio_oe, so_o, so_oe, pma, s2x, upd, sfe;
	wire [1:0] sfsc;
	wire [dscp_pkg::NUM_REGS*8-1:0] cfg;
	// A released line toggles so that a stale value is never read as data.
	wire sdio_line = sdio_oe ? sdio_o : sd_oe ? sd_o : junk;
	wire out_line = so_oe ? so_o : junk;

	dscp_master m (.sclk(sclk), .select_n(select_n), .sd_o(sd_o), .sd_oe(sd_oe),
		.sdio_line(sdio_line), .out_line(out_line));
	dscp_top #(.VERSION_ID(VER)) uut (.ref_clk(ref_clk), .rstn(rstn), .sclk(sclk),
		.select_n(select_n), .sdio_i(sdio_line), .sdio_o(sdio_o), .sdio_oe(sdio_oe),
		.serial_out_pin_i(out_line), .serial_out_pin_o(so_o), .serial_out_pin_oe(so_oe),
		.pin_mode(pin_mode), .status_in(status), .cfg_regs(cfg), .cfg_update(upd),
		.pin_mode_active(pma), .static_interp_2x(s2x), .static_fsc(sfsc), .static_fifo_en(sfe));

	always #25 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		junk <= ~junk;
		cycles++;
		if (upd) begin
			upd_cnt++;
		end
		if (cycles == 30000) begin
			miscompares++;
			test_done();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	function automatic logic [7:0] cb(input int a);
		return cfg[8*a +: 8];
	endfunction : cb
	task automatic xfer(input logic rd, input logic [12:0] a, input int n, input logic [31:0] d,
		input logic use_out, input logic stall);
		logic [7:0] b;
		m.frame(1'b1);
		if (wide) begin
			m.xbyte({rd, 2'(n - 1), a[12:8]}, lsb, 1'b0, 1'b0, b);
			m.xbyte(a[7:0], lsb, 1'b0, 1'b0, b);
		end else
			m.xbyte({rd, 2'(n - 1), a[4:0]}, lsb, 1'b0, 1'b0, b);
		for (int k = 0; k < n; k++) begin
			m.xbyte(d[8*k +: 8], lsb, rd, use_out, b);
			q[8*k +: 8] = b;
			if (stall && k == 0) begin
				m.frame(1'b0);
				#500 m.frame(1'b1);
			end
		end
		m.frame(1'b0);
		repeat (12) @(posedge ref_clk);
	endtask : xfer

	task automatic t_basic;
		chk({cb(15), cb(14), cb(2)}, 32'hcac002);
		xfer(1'b0, 13'h0f, 2, 32'h3412, 1'b0, 1'b0);
		chk({cb(15), cb(14)}, 16'h1234);
		chk(upd_cnt, 32'h2);
		xfer(1'b1, 13'h0f, 2, 32'h0, 1'b1, 1'b0);
		chk(q[15:0], 16'h3412);
		xfer(1'b0, 13'h0b, 4, 32'h44332211, 1'b0, 1'b0);
		chk({cb(11), cb(10), cb(9), cb(8)}, 32'h11223344);
		#1 status = 8'hc3;
		xfer(1'b1, 13'h07, 1, 32'h0, 1'b1, 1'b0);
		chk(q[7:0], 8'hc3);
		xfer(1'b1, 13'h1f, 1, 32'h0, 1'b1, 1'b0);
		chk(q[7:0], VER);
		$display("test basic done");
	endtask : t_basic
	task automatic t_stall;
		logic [7:0] b;
		xfer(1'b0, 13'h03, 2, 32'h6677, 1'b0, 1'b1);
		chk({cb(3), cb(2)}, 16'h7766);
		m.frame(1'b1);
		m.xbyte(8'h05, lsb, 1'b0, 1'b0, b);
		m.zeros(4);
		m.frame(1'b0);
		xfer(1'b0, 13'h05, 1, 32'h3c, 1'b0, 1'b0);
		chk(cb(5), 8'h3c);
		$display("test stall done");
	endtask : t_stall
	task automatic t_order;
		xfer(1'b0, 13'h00, 1, 32'h40, 1'b0, 1'b0);
		lsb = 1'b1;
		xfer(1'b0, 13'h08, 2, 32'h2211, 1'b0, 1'b0);
		chk({cb(9), cb(8)}, 16'h2211);
		xfer(1'b1, 13'h08, 2, 32'h0, 1'b1, 1'b0);
		chk(q[15:0], 16'h2211);
		m.frame(1'b1);
		m.zeros(27);
		m.frame(1'b0);
		lsb = 1'b0;
		repeat (12) @(posedge ref_clk);
		chk(cb(0), 8'h00);
		$display("test order done");
	endtask : t_order
	task automatic t_modes;
		xfer(1'b0, 13'h00, 1, 32'h80, 1'b0, 1'b0);
		xfer(1'b1, 13'h0e, 1, 32'h0, 1'b0, 1'b0);
		chk(q[7:0], 8'h34);
		xfer(1'b0, 13'h04, 1, 32'h99, 1'b0, 1'b0);
		xfer(1'b0, 13'h00, 1, 32'h20, 1'b0, 1'b0);
		chk({cb(0), cb(4), cb(15), cb(5)}, 32'h0099ca00);
		xfer(1'b0, 13'h00, 1, 32'h10, 1'b0, 1'b0);
		wide = 1'b1;
		xfer(1'b0, 13'h06, 1, 32'h5e, 1'b0, 1'b0);
		xfer(1'b1, 13'h06, 1, 32'h0, 1'b1, 1'b0);
		chk({cb(6), q[7:0]}, 16'h5e5e);
		xfer(1'b0, 13'h00, 1, 32'h0, 1'b0, 1'b0);
		wide = 1'b0;
		chk(cb(0), 8'h00);
		$display("test modes done");
	endtask : t_modes
	task automatic t_pin;
		#1 pin_mode = 1'b1;
		m.level(1'b1);
		repeat (10) @(posedge ref_clk);
		chk({pma, s2x, sfsc[0], sfe}, 4'hd);
		#1 m.frame(1'b1);
		repeat (10) @(posedge ref_clk);
		chk({s2x, sfe}, 2'h1);
		#1 m.frame(1'b0);
		pin_mode = 1'b0;
		repeat (10) @(posedge ref_clk);
		chk({pma, s2x, sfe}, 3'h0);
		$display("test pin done");
	endtask : t_pin

	task automatic test_done;
		$display("checks=%0d miscompares=%0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : test_done

	initial begin
		repeat (2) @(posedge ref_clk);
		#1 rstn = 1'b1;
		t_basic();
		t_stall();
		t_order();
		t_modes();
		t_pin();
		test_done();
	end
endmodule : dac_serial_config_port_tb_top
